// *** include/tune_drv_pkg.sv ***
// Purpose: shared constants and types for the sampling-tuning and driver-select block
// Assumes: 32-bit apb data, one register per aligned word
// Notes:   register index times four gives the byte address
package tune_drv_pkg;
    // register indices and byte addresses
    localparam logic [11:0] HC2_INDEX       = 12'h03E;
    localparam logic [11:0] HC2_ADDR        = {HC2_INDEX[9:0], 2'b00};
    localparam logic [11:0] IRQ_STATUS_ADDR = 12'h100;
    localparam logic [11:0] IRQ_MASK_ADDR   = 12'h104;
    localparam logic [11:0] CLK_CTRL_ADDR   = 12'h108;
    localparam logic [11:0] TUNE_STATE_ADDR = 12'h10C;
    // field positions in host_control_second
    localparam int MODE_LSB      = 0;
    localparam int LOW_V_BIT     = 3;
    localparam int DRIVE_LSB     = 4;
    localparam int TUNE_START    = 6;
    localparam int SAMPLE_CHOICE = 7;
    localparam int ASYNC_IRQ_BIT = 14;
    localparam int PRESET_EN_BIT = 15;
    // interrupt status bits
    localparam int EV_TUNE_OK    = 0;
    localparam int EV_TUNE_FAIL  = 1;
    localparam int EV_TUNE_ABORT = 2;
    localparam int EV_W          = 3;
    // reset values
    localparam logic [1:0]  DRIVE_RST    = 2'h0;
    localparam logic [2:0]  MODE_RST     = 3'h0;
    localparam logic [9:0]  CLK_DIV_RST  = 10'h000;
    localparam logic [EV_W-1:0] MASK_RST = 3'h0;
    // timing: settle time of the delay line after each tap change
    localparam int CLK_PERIOD_PS  = 4000;
    localparam int TAP_SETTLE_NS  = 40;
    localparam int TAP_SETTLE_CYC = (TAP_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // driver types
    typedef enum logic [1:0] {
        DRV_B = 2'h0,
        DRV_A = 2'h1,
        DRV_C = 2'h2,
        DRV_D = 2'h3
    } drive_type_t;
    // tuning engine states, gray along idle-settle-probe-done
    typedef enum logic [1:0] {
        T_IDLE   = 2'h0,
        T_SETTLE = 2'h1,
        T_PROBE  = 2'h3,
        T_DONE   = 2'h2
    } tune_state_t;
    // card receive lines: one command and four data
    typedef struct packed {
        logic       cmd;
        logic [3:0] dat;
    } rx_lines_t;
endpackage : tune_drv_pkg

// *** rtl/sample_tuning_drive_ctrl.sv ***
// Purpose: tuning control, sampling-clock choice and output driver type select
// Assumes: apb4 slave, zero wait states; card lines and pass flag arrive asynchronously
// Notes:   tuning sweeps delay taps from zero; a kept result re-checks only the held tap
// Behaviour
// - start bit runs tuning, self-clears when done
// - writing zero to start aborts tuning
// - choice bit reports result after start clears
// - writing one to choice bit ignored
// - writing zero to choice resets tuner; done here only while tuning is idle, ignored during a run
// - starting a full run clears choice bit
// - choice one selects tuned sampling clock
// - drive field encodes types B, A, C, D
// - drive field only acts at low voltage
// - preset enable loads drive field automatically
// - preset enable picks clock and drive automatically
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ps
module sample_tuning_drive_ctrl #(
    parameter int TAPS = 16
) (
    // apb slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // card lines from both sampling paths, and pass flag of the tuning compare
    input  wire tune_drv_pkg::rx_lines_t rx_fixed,
    input  wire tune_drv_pkg::rx_lines_t rx_tuned,
    input  wire logic        tune_pass,
    // preset values for the selected mode
    input  wire logic [1:0]  preset_drive,
    input  wire logic [9:0]  preset_clk_div,
    // outputs to pads, clock generator and receive path
    output tune_drv_pkg::rx_lines_t rx_out,
    output logic [$clog2(TAPS)-1:0] tap_sel,
    output logic             tuned_clk_sel,
    output tune_drv_pkg::drive_type_t drive_type_out,
    output logic             low_voltage_io_enable,
    output logic [2:0]       mode_sel,
    output logic [9:0]       clk_div,
    output logic             async_irq_en,
    output logic             irq
);
    localparam int TW = $clog2(TAPS);
    localparam int CW = $clog2(tune_drv_pkg::TAP_SETTLE_CYC + 1);
    localparam logic [CW-1:0] SETTLE_LAST = CW'(tune_drv_pkg::TAP_SETTLE_CYC - 1);
    localparam logic [TW-1:0] TAP_LAST    = TW'(TAPS - 1);

    tune_drv_pkg::tune_state_t state_r;
    tune_drv_pkg::rx_lines_t   fixed_m_r, fixed_s_r, tuned_m_r, tuned_s_r;
    logic                      pass_m_r, pass_s_r;
    logic                      start_r, choice_r, full_r, pass_r;
    logic [TW-1:0]             tap_r;
    logic [CW-1:0]             cnt_r;
    logic                      preset_en_r, async_r, low_v_r;
    logic [1:0]                drive_r;
    logic [2:0]                mode_r;
    logic [9:0]                clk_div_r;
    logic [tune_drv_pkg::EV_W-1:0] sts_r, mask_r, ev_set;
    logic                      setup, wr_acc, hc2_wr, lo_wr, hi_wr;
    logic                      start_wr, abort_wr, reset_wr;
    logic                      mapped;
    logic [31:0]               rd_nxt;

    // access decode; writes land in the access phase only
    assign setup    = psel & ~penable;
    assign wr_acc   = psel & penable & pwrite;
    assign hc2_wr   = wr_acc & (paddr == tune_drv_pkg::HC2_ADDR);
    assign lo_wr    = hc2_wr & pstrb[0];
    assign hi_wr    = hc2_wr & pstrb[1];
    assign start_wr = lo_wr & pwdata[tune_drv_pkg::TUNE_START] & (state_r == tune_drv_pkg::T_IDLE);
    assign abort_wr = lo_wr & ~pwdata[tune_drv_pkg::TUNE_START] & start_r;
    // a write of one to the choice bit is simply not decoded
    assign reset_wr = lo_wr & ~pwdata[tune_drv_pkg::SAMPLE_CHOICE];
    assign pready   = 1'b1;

    // two-stage synchronisers for card-side inputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fixed_m_r <= '0;
            fixed_s_r <= '0;
            tuned_m_r <= '0;
            tuned_s_r <= '0;
            pass_m_r  <= 1'b0;
            pass_s_r  <= 1'b0;
        end else begin
            fixed_m_r <= rx_fixed;
            fixed_s_r <= fixed_m_r;
            tuned_m_r <= rx_tuned;
            tuned_s_r <= tuned_m_r;
            pass_m_r  <= tune_pass;
            pass_s_r  <= pass_m_r;
        end
    end

    // receive mux: the choice bit steers which sampling path reaches the core
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_out <= '0;
        end else begin
            rx_out <= choice_r ? tuned_s_r : fixed_s_r;
        end
    end

    // tuning engine; a choice bit kept at one means only the held tap is re-checked
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r  <= tune_drv_pkg::T_IDLE;
            start_r  <= 1'b0;
            choice_r <= 1'b0;
            full_r   <= 1'b0;
            pass_r   <= 1'b0;
            tap_r    <= '0;
            cnt_r    <= '0;
        end else begin
            unique case (state_r)
                tune_drv_pkg::T_IDLE: begin
                    if (start_wr) begin
                        start_r <= 1'b1;
                        full_r  <= ~choice_r | reset_wr;
                        pass_r  <= 1'b0;
                        cnt_r   <= '0;
                        state_r <= tune_drv_pkg::T_SETTLE;
                        if (~choice_r | reset_wr) begin
                            choice_r <= 1'b0;
                            tap_r    <= '0;
                        end
                    end else if (reset_wr) begin
                        choice_r <= 1'b0;
                        tap_r    <= '0;
                    end
                end
                tune_drv_pkg::T_SETTLE: begin
                    if (abort_wr) begin
                        start_r <= 1'b0;
                        state_r <= tune_drv_pkg::T_IDLE;
                    end else if (cnt_r == SETTLE_LAST) begin
                        state_r <= tune_drv_pkg::T_PROBE;
                    end else begin
                        cnt_r <= CW'(cnt_r + 1'b1);
                    end
                end
                tune_drv_pkg::T_PROBE: begin
                    cnt_r <= '0;
                    if (abort_wr) begin
                        start_r <= 1'b0;
                        state_r <= tune_drv_pkg::T_IDLE;
                    end else if (pass_s_r) begin
                        pass_r  <= 1'b1;
                        state_r <= tune_drv_pkg::T_DONE;
                    end else if (!full_r || tap_r == TAP_LAST) begin
                        state_r <= tune_drv_pkg::T_DONE;
                    end else begin
                        tap_r   <= TW'(tap_r + 1'b1);
                        state_r <= tune_drv_pkg::T_SETTLE;
                    end
                end
                tune_drv_pkg::T_DONE: begin
                    // result wins over a same-cycle software clear
                    start_r  <= 1'b0;
                    choice_r <= pass_r;
                    if (!pass_r) begin
                        tap_r <= '0;
                    end
                    state_r <= tune_drv_pkg::T_IDLE;
                end
            endcase
        end
    end

    // plain software fields; the drive field follows the preset while enabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            preset_en_r <= 1'b0;
            async_r     <= 1'b0;
            low_v_r     <= 1'b0;
            drive_r     <= tune_drv_pkg::DRIVE_RST;
            mode_r      <= tune_drv_pkg::MODE_RST;
            clk_div_r   <= tune_drv_pkg::CLK_DIV_RST;
        end else begin
            if (hi_wr) begin
                preset_en_r <= pwdata[tune_drv_pkg::PRESET_EN_BIT];
                async_r     <= pwdata[tune_drv_pkg::ASYNC_IRQ_BIT];
            end
            if (lo_wr) begin
                low_v_r <= pwdata[tune_drv_pkg::LOW_V_BIT];
                mode_r  <= pwdata[tune_drv_pkg::MODE_LSB +: 3];
            end
            if (preset_en_r) begin
                drive_r <= preset_drive;
            end else if (lo_wr) begin
                drive_r <= pwdata[tune_drv_pkg::DRIVE_LSB +: 2];
            end
            if (wr_acc && paddr == tune_drv_pkg::CLK_CTRL_ADDR && pstrb[0]) begin
                clk_div_r[7:0] <= pwdata[7:0];
            end
            if (wr_acc && paddr == tune_drv_pkg::CLK_CTRL_ADDR && pstrb[1]) begin
                clk_div_r[9:8] <= pwdata[9:8];
            end
        end
    end

    // event flags: set wins over a write-one clear
    assign ev_set[tune_drv_pkg::EV_TUNE_OK]    = (state_r == tune_drv_pkg::T_DONE) & pass_r;
    assign ev_set[tune_drv_pkg::EV_TUNE_FAIL]  = (state_r == tune_drv_pkg::T_DONE) & ~pass_r;
    assign ev_set[tune_drv_pkg::EV_TUNE_ABORT] = abort_wr & (state_r != tune_drv_pkg::T_DONE);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sts_r  <= '0;
            mask_r <= tune_drv_pkg::MASK_RST;
        end else begin
            if (wr_acc && paddr == tune_drv_pkg::IRQ_STATUS_ADDR && pstrb[0]) begin
                sts_r <= (sts_r & ~pwdata[tune_drv_pkg::EV_W-1:0]) | ev_set;
            end else begin
                sts_r <= sts_r | ev_set;
            end
            if (wr_acc && paddr == tune_drv_pkg::IRQ_MASK_ADDR && pstrb[0]) begin
                mask_r <= pwdata[tune_drv_pkg::EV_W-1:0];
            end
        end
    end

    assign irq = |(sts_r & mask_r);

    // read mux, captured in the setup cycle so data comes from flops
    always_comb begin
        rd_nxt = 32'h0000_0000;
        mapped = 1'b1;
        unique case (paddr)
            tune_drv_pkg::HC2_ADDR: begin
                rd_nxt[tune_drv_pkg::PRESET_EN_BIT]    = preset_en_r;
                rd_nxt[tune_drv_pkg::ASYNC_IRQ_BIT]    = async_r;
                rd_nxt[tune_drv_pkg::SAMPLE_CHOICE]    = choice_r;
                rd_nxt[tune_drv_pkg::TUNE_START]       = start_r;
                rd_nxt[tune_drv_pkg::DRIVE_LSB +: 2]   = drive_r;
                rd_nxt[tune_drv_pkg::LOW_V_BIT]        = low_v_r;
                rd_nxt[tune_drv_pkg::MODE_LSB +: 3]    = mode_r;
            end
            tune_drv_pkg::IRQ_STATUS_ADDR: rd_nxt[tune_drv_pkg::EV_W-1:0] = sts_r;
            tune_drv_pkg::IRQ_MASK_ADDR:   rd_nxt[tune_drv_pkg::EV_W-1:0] = mask_r;
            tune_drv_pkg::CLK_CTRL_ADDR:   rd_nxt[9:0] = clk_div_r;
            tune_drv_pkg::TUNE_STATE_ADDR: rd_nxt = {22'h000000, state_r, 8'(tap_r)};
            default:                       mapped = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= pwrite ? 32'h0000_0000 : rd_nxt;
            pslverr <= ~mapped;
        end
    end

    // outputs to the pads and clock generator
    assign tap_sel               = tap_r;
    assign tuned_clk_sel         = choice_r;
    // type B is forced outside low-voltage signalling
    assign drive_type_out        = low_v_r ? tune_drv_pkg::drive_type_t'(drive_r)
                                           : tune_drv_pkg::DRV_B;
    assign low_voltage_io_enable = low_v_r;
    assign mode_sel              = mode_r;
    assign clk_div               = preset_en_r ? preset_clk_div : clk_div_r;
    assign async_irq_en          = async_r;

    // checks
    sequence s_start_wr;
        start_wr;
    endsequence
    sequence s_abort_wr;
        abort_wr && state_r != tune_drv_pkg::T_DONE;
    endsequence
    sequence s_tune_done;
        state_r == tune_drv_pkg::T_DONE;
    endsequence

    a_start_runs: assert property (@(posedge pclk) disable iff (!presetn)
        s_start_wr |=> start_r && state_r == tune_drv_pkg::T_SETTLE)
        else $error("start write did not begin tuning");
    a_done_clears: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == tune_drv_pkg::T_DONE |=> !start_r && state_r == tune_drv_pkg::T_IDLE)
        else $error("start bit not cleared at end of tuning");
    a_abort_stops: assert property (@(posedge pclk) disable iff (!presetn)
        s_abort_wr |=> !start_r && state_r == tune_drv_pkg::T_IDLE)
        else $error("abort write did not stop tuning");
    // an abort leaves its own event behind for software
    a_abort_event: assert property (@(posedge pclk) disable iff (!presetn)
        s_abort_wr |=> sts_r[tune_drv_pkg::EV_TUNE_ABORT])
        else $error("abort did not raise its event");
    // an abort also drops the start bit, so only a finished run is checked here
    a_result_valid: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(start_r) && $past(state_r) == tune_drv_pkg::T_DONE
        |-> choice_r == $past(pass_r) && sts_r != '0)
        else $error("choice bit does not match tuning result");
    // each finished run leaves the matching event in the status register
    a_done_event: assert property (@(posedge pclk) disable iff (!presetn)
        s_tune_done |=> ($past(pass_r) ? sts_r[tune_drv_pkg::EV_TUNE_OK]
        : sts_r[tune_drv_pkg::EV_TUNE_FAIL]))
        else $error("tuning result event missing");
    // a start write while busy must not restart or drop the run
    a_busy_start: assert property (@(posedge pclk) disable iff (!presetn)
        lo_wr && pwdata[tune_drv_pkg::TUNE_START] && (state_r == tune_drv_pkg::T_SETTLE
        || state_r == tune_drv_pkg::T_PROBE) |=> start_r)
        else $error("start write while busy disturbed tuning");
    // the choice bit moves only by a result or by a zero write
    a_choice_source: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(choice_r) |-> $past(state_r) == tune_drv_pkg::T_DONE || $past(reset_wr))
        else $error("choice bit changed without result or zero write");
    a_one_ignored: assert property (@(posedge pclk) disable iff (!presetn)
        lo_wr && pwdata[tune_drv_pkg::SAMPLE_CHOICE] && !choice_r
        && state_r != tune_drv_pkg::T_DONE |=> !choice_r)
        else $error("write of one changed the choice bit");
    a_zero_resets: assert property (@(posedge pclk) disable iff (!presetn)
        reset_wr && state_r == tune_drv_pkg::T_IDLE |=> !choice_r && tap_r == '0)
        else $error("zero write did not reset tuner");
    a_full_clears: assert property (@(posedge pclk) disable iff (!presetn)
        s_start_wr ##1 full_r |-> !choice_r)
        else $error("full run left choice bit set");
    // a quick run keeps the held tap and the tuned clock in use
    a_quick_keeps: assert property (@(posedge pclk) disable iff (!presetn)
        start_wr && choice_r && !reset_wr |=> choice_r && tap_r == $past(tap_r))
        else $error("quick run lost the held tap");
    a_rx_path: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 rx_out == ($past(choice_r) ? $past(tuned_s_r) : $past(fixed_s_r)))
        else $error("receive path does not follow choice bit");
    a_drive_low_v: assert property (@(posedge pclk) disable iff (!presetn)
        !low_voltage_io_enable |-> drive_type_out == tune_drv_pkg::DRV_B)
        else $error("driver type applied outside low voltage");
    a_preset_load: assert property (@(posedge pclk) disable iff (!presetn)
        preset_en_r |=> drive_r == $past(preset_drive))
        else $error("drive field did not follow preset");
    // the divider comes from the preset while preset enable is on
    a_preset_clock: assert property (@(posedge pclk) disable iff (!presetn)
        preset_en_r |-> clk_div == preset_clk_div)
        else $error("clock divider did not follow preset");
endmodule : sample_tuning_drive_ctrl

// *** verification/card_line_model.sv ***
// Purpose: card side of the receive lines and of the tuning compare
// Assumes: the card answers the tuning pattern only at one good tap
// Notes:   fixed and tuned paths carry distinct patterns so the chosen path shows
`timescale 1ns/1ps
module card_line_model #(
    parameter int TW = 2
) (
    // clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // tap under test and where the card's eye really is
    input  wire logic [TW-1:0]      tap_sel,
    input  wire logic [TW-1:0]      pass_tap,
    input  wire logic               pass_en,
    // lines as seen through both sampling paths
    output tune_drv_pkg::rx_lines_t rx_fixed,
    output tune_drv_pkg::rx_lines_t rx_tuned,
    output logic                    tune_pass
);
    // inverse patterns on the two paths, so a wrong mux shows every bit
    assign rx_fixed = 5'h0A;
    assign rx_tuned = 5'h15;

    // compare result lags the tap by a cycle, as a real pattern check would
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tune_pass <= 1'b0;
        end else begin
            tune_pass <= pass_en && (tap_sel == pass_tap);
        end
    end
endmodule : card_line_model

// *** verification/tb_sample_tuning_drive_ctrl.sv ***
// Purpose: register-level tests of tuning, sampling choice and driver select
// Assumes: zero wait apb, TAPS reduced to 4 to keep tuning runs short
// Notes:   expected values come from field layout, never from the design
`timescale 1ns/1ps
module tb_sample_tuning_drive_ctrl;
    localparam int          TAPS = 4;
    localparam int          TW   = $clog2(TAPS);
    localparam logic [11:0] HC2  = tune_drv_pkg::HC2_ADDR;
    localparam logic [11:0] STS  = tune_drv_pkg::IRQ_STATUS_ADDR;
    localparam logic [11:0] MSK  = tune_drv_pkg::IRQ_MASK_ADDR;
    localparam logic [11:0] CLKR = tune_drv_pkg::CLK_CTRL_ADDR;
    // bus and side signals
    logic                      pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0]               paddr;
    logic [31:0]               pwdata, prdata, rd;
    logic [3:0]                pstrb;
    logic                      err, tune_pass, pass_en, tuned_clk_sel;
    logic                      low_voltage_io_enable, async_irq_en, irq;
    logic [1:0]                preset_drive;
    logic [9:0]                preset_clk_div, clk_div;
    logic [2:0]                mode_sel;
    logic [TW-1:0]             tap_sel, pass_tap;
    tune_drv_pkg::rx_lines_t   rx_fixed, rx_tuned, rx_out;
    tune_drv_pkg::drive_type_t drive_type_out;
    int                        n_errors, n_checks, cycles;

    sample_tuning_drive_ctrl #(.TAPS(TAPS)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .rx_fixed(rx_fixed), .rx_tuned(rx_tuned), .tune_pass(tune_pass),
        .preset_drive(preset_drive), .preset_clk_div(preset_clk_div), .rx_out(rx_out),
        .tap_sel(tap_sel), .tuned_clk_sel(tuned_clk_sel), .drive_type_out(drive_type_out),
        .low_voltage_io_enable(low_voltage_io_enable), .mode_sel(mode_sel),
        .clk_div(clk_div), .async_irq_en(async_irq_en), .irq(irq));

    card_line_model #(.TW(TW)) u_card (
        .pclk(pclk), .presetn(presetn), .tap_sel(tap_sel), .pass_tap(pass_tap),
        .pass_en(pass_en), .rx_fixed(rx_fixed), .rx_tuned(rx_tuned), .tune_pass(tune_pass));

    // free-running clock, 4 ns
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // hang guard: a run far longer than the tests need counts as a failure
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            $display("Error at %0t: timeout", $time);
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp, "register read");
    endtask : rdchk

    // poll until the start bit drops; bounded so a stuck engine still ends
    task automatic wait_tune();
        int k;
        k = 0;
        do begin
            apb(1'b0, HC2, 32'h0);
            k++;
        end while (rd[tune_drv_pkg::TUNE_START] !== 1'b0 && k < 100);
    endtask : wait_tune

    task automatic end_test(input string name);
        $display("test %s done at %0t, mismatches %0d", name, $time, n_errors);
    endtask : end_test

    // main sequence
    initial begin
        {psel, penable, pwrite, paddr, pwdata, n_errors, n_checks, cycles} = '0;
        presetn = 1'b0;
        pstrb = 4'hF;
        pass_tap = 2'h2;
        pass_en = 1'b1;
        preset_drive = 2'h2;
        preset_clk_div = 10'h155;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        check(drive_type_out, 32'h0, "drive after reset"); // type B
        check(tuned_clk_sel, 32'h0, "choice after reset"); // fixed clock
        rdchk(HC2, 32'h0); // all fields clear
        apb(1'b0, 12'h200, 32'h0);
        check(err, 32'h1, "unmapped error");
        check(rd, 32'h0, "unmapped data");
        wr(HC2, 32'h88);
        rdchk(HC2, 32'h08); // one to choice ignored
        wr(HC2, 32'h400D);
        rdchk(HC2, 32'h400D);
        check(mode_sel, 32'h5, "mode field");
        check(async_irq_en, 32'h1, "async irq enable");
        check(low_voltage_io_enable, 32'h1, "low voltage enable");
        end_test("reset");
        for (int i = 0; i < 4; i++) begin
            wr(HC2, 32'h08 | (i << 4)); // all types taken as supported
            rdchk(HC2, 32'h08 | (i << 4));
            check(drive_type_out, i, "drive code"); // each code
        end
        wr(HC2, 32'h30);
        rdchk(HC2, 32'h30);
        check(drive_type_out, 32'h0, "drive at 3.3V"); // forced B
        wr(HC2, 32'h8008);
        rdchk(HC2, 32'h8028); // field from preset
        check(drive_type_out, 32'h2, "preset drive"); // type C
        check(clk_div, 32'h155, "preset divider"); // preset clock
        wr(HC2, 32'h0008);
        wr(HC2, 32'h0008);
        wr(CLKR, 32'h2AA);
        rdchk(CLKR, 32'h2AA);
        check(clk_div, 32'h2AA, "own divider"); // software clock
        end_test("drive");
        wr(MSK, 32'h7);
        wr(HC2, 32'h48); // start full run
        wait_tune();
        check(rd, 32'h88, "tune success"); // cleared, success
        check(tap_sel, 32'h2, "passing tap");
        rdchk(tune_drv_pkg::TUNE_STATE_ADDR, {22'h0, tune_drv_pkg::T_IDLE, 8'h02});
        check(tuned_clk_sel, 32'h1, "tuned clock"); // tuned path
        repeat (4) @(posedge pclk);
        check({27'h0, rx_out}, 32'h15, "tuned lines"); // tuned data
        rdchk(STS, 32'h1);
        check(irq, 32'h1, "irq on success");
        wr(STS, 32'h1);
        rdchk(STS, 32'h0);
        check(irq, 32'h0, "irq cleared");
        wr(HC2, 32'h48);
        rdchk(HC2, 32'h48); // start clears choice
        wait_tune();
        check(rd, 32'h88, "full rerun");
        wr(HC2, 32'hC8); // keep choice for a quick run
        wait_tune();
        check(rd, 32'h88, "quick retune");
        check(tap_sel, 32'h2, "held tap");
        wr(STS, 32'h7);
        end_test("tune");
        wr(HC2, 32'h08); // no receive in flight while choice moves
        rdchk(HC2, 32'h08); // zero resets tuner
        check(tuned_clk_sel, 32'h0, "fixed clock");
        check(tap_sel, 32'h0, "tap after zero write");
        repeat (4) @(posedge pclk);
        check({27'h0, rx_out}, 32'h0A, "fixed lines"); // fixed data
        pass_en <= 1'b0;
        wr(HC2, 32'h48);
        wait_tune();
        check(rd, 32'h08, "tune failure"); // zero means failure
        check(tap_sel, 32'h0, "tap after failure");
        rdchk(STS, 32'h2);
        wr(MSK, 32'h5);
        rdchk(MSK, 32'h5);
        check(irq, 32'h0, "masked irq");
        wr(MSK, 32'h7);
        rdchk(MSK, 32'h7);
        check(irq, 32'h1, "unmasked irq");
        wr(STS, 32'h2);
        end_test("failure");
        wr(HC2, 32'h48);
        repeat (5) @(posedge pclk);
        wr(HC2, 32'h08); // zero to start aborts
        rdchk(HC2, 32'h08);
        rdchk(STS, 32'h4); // abort event
        end_test("abort");
        report_and_stop();
    end
endmodule : tb_sample_tuning_drive_ctrl
